// ---- src/alarm_compare.sv ----
`timescale 1ns/1ns
module alarm_compare (
	// Running clock and alarm settings
	input wire rtc_alarm_pkg::bcd_time_t now_time,
	input wire rtc_alarm_pkg::bcd_time_t alarm_time,
	input wire logic [3:0] repeat_code,
	// Result
	output logic match
);
	import rtc_alarm_pkg::*;

	logic [3:0] use_field;
	logic [3:0] field_ok;
	logic [31:0] masks;

	assign masks = {DATE_MASK, HOURS_MASK, MINUTES_MASK, SECONDS_MASK};

	always_comb begin
		unique case (repeat_code)
			RPT_MATCH_SECONDS: use_field = USE_SECONDS;
			RPT_MATCH_MINUTES: use_field = USE_MINUTES;
			RPT_MATCH_HOURS: use_field = USE_HOURS;
			RPT_MATCH_DATE: use_field = USE_DATE;
			RPT_EVERY_SECOND: use_field = USE_NONE;
			// Unlisted codes fire every second to expose bad setup
			default: use_field = USE_NONE;
		endcase
	end

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_field
			assign field_ok[i] = !use_field[i] ||
				((now_time[i*8 +: 8] & masks[i*8 +: 8]) ==
				(alarm_time[i*8 +: 8] & masks[i*8 +: 8]));
		end
	endgenerate

	assign match = &field_ok;
endmodule

// ---- src/reg_decode.sv ----
`timescale 1ns/1ns
module reg_decode (
	// Bus byte address
	input wire logic [rtc_alarm_pkg::ADDR_W-1:0] paddr,
	// Selected register
	output rtc_alarm_pkg::reg_sel_t sel
);
	import rtc_alarm_pkg::*;

	always_comb begin
		sel = SEL_NONE;
		if (paddr[1:0] == 2'b00) begin
			unique case (paddr[ADDR_W-1:2])
				IDX_FLAGS[ADDR_W-3:0]: sel = SEL_FLAGS;
				IDX_INTERRUPTS[ADDR_W-3:0]: sel = SEL_INTERRUPTS;
				IDX_ALARM_DATE[ADDR_W-3:0]: sel = SEL_DATE;
				IDX_ALARM_HOURS[ADDR_W-3:0]: sel = SEL_HOURS;
				IDX_ALARM_MINUTES[ADDR_W-3:0]: sel = SEL_MINUTES;
				IDX_ALARM_SECONDS[ADDR_W-3:0]: sel = SEL_SECONDS;
				default: sel = SEL_NONE;
			endcase
		end
	end
endmodule

// ---- src/rtc_alarm_match_irq.sv ----
// Contract
// - Four alarm bytes: date, hours, minutes, seconds
// - Alarm fires per day, hour, minute, second
// - Matching continues in battery back-up mode
// - Repeat bits pick which fields compare
// - Unlisted repeat codes act as every second
// - Flag change seen only on new access
// - Match on selected fields sets alarm flag
// - Interrupt enable drives interrupt on match
// - Flags read clears flag and interrupt
// - Clearing read still returns set flag
// - Back-up interrupt needs both enables set
// - Power-up clears both interrupt enables
// - Flag retained through power-down deselect
// - Alarm flag is read-only to software
// - Repeat bits held one per alarm byte
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module rtc_alarm_match_irq (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// APB slave
	input wire rtc_alarm_pkg::apb_req_t apb_req,
	output rtc_alarm_pkg::apb_rsp_t apb_rsp,
	// Running clock from the oscillator chain
	input wire rtc_alarm_pkg::bcd_time_t now_time,
	input wire logic second_update,
	input wire logic backup_mode,
	// Open-drain interrupt, active low
	output logic irq_freqtest_out,
	output logic irq_freqtest_oe
);
	import rtc_alarm_pkg::*;

	typedef struct packed {
		bcd_time_t alarm;
		logic [3:0] alarm_repeat_bits;
		logic alarm_irq_enable;
		logic backup_alarm_enable;
		logic alarm_match_flag;
		logic irq_low;
		logic irq_level;
		logic flag_returned;
		apb_rsp_t rsp;
	} state_t;

	state_t state_reg;
	state_t state_next;
	reg_sel_t sel;
	logic match;
	logic setup;
	logic access;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	// Completed transfers and per-register write strobes
	logic rd_access;
	logic wr_access;
	logic wr_interrupts;
	logic wr_date;
	logic wr_hours;
	logic wr_minutes;
	logic wr_seconds;
	logic wr_flags;
	// Written byte split into field and repeat bit
	logic [7:0] date_field;
	logic [7:0] hours_field;
	logic [7:0] minutes_field;
	logic [7:0] seconds_field;
	logic wr_repeat_bit;
	// Answer prepared in the setup cycle
	logic rsp_error;
	logic returns_flag;
	// Flag and interrupt events
	logic flags_clear;
	logic alarm_disabled;
	logic alarm_event;
	logic irq_permitted;
	logic irq_set;

	reg_decode u_decode (
		.paddr(apb_req.paddr),
		.sel(sel)
	);

	alarm_compare u_compare (
		.now_time(now_time),
		.alarm_time(state_reg.alarm),
		.repeat_code(state_reg.alarm_repeat_bits),
		.match(match)
	);

	assign setup = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable && state_reg.rsp.pready;
	assign wbyte = apb_req.pwdata[7:0];

	// A transfer completes in the access cycle in which pready stands
	assign rd_access = access && !apb_req.pwrite;
	assign wr_access = access && apb_req.pwrite;

	assign wr_interrupts = wr_access && (sel == SEL_INTERRUPTS);
	assign wr_date = wr_access && (sel == SEL_DATE);
	assign wr_hours = wr_access && (sel == SEL_HOURS);
	assign wr_minutes = wr_access && (sel == SEL_MINUTES);
	assign wr_seconds = wr_access && (sel == SEL_SECONDS);
	assign wr_flags = wr_access && (sel == SEL_FLAGS);

	// Unused high bits are dropped so they never reach the compare
	assign date_field = wbyte & DATE_MASK;
	assign hours_field = wbyte & HOURS_MASK;
	assign minutes_field = wbyte & MINUTES_MASK;
	assign seconds_field = wbyte & SECONDS_MASK;
	assign wr_repeat_bit = wbyte[RPT_BIT];

	assign rsp_error = (sel == SEL_NONE);
	// Remembered so the clear acts only on a flag the host has seen
	assign returns_flag = (sel == SEL_FLAGS) && !apb_req.pwrite &&
		state_reg.alarm_match_flag;
	assign flags_clear = rd_access && (sel == SEL_FLAGS) &&
		state_reg.flag_returned;

	// Zero date with all repeat bits clear is the switched-off alarm
	assign alarm_disabled = (state_reg.alarm.date == ALARM_RESET) &&
		(state_reg.alarm_repeat_bits == RPT_MATCH_DATE);
	// Compare is taken only on the once-per-second update
	assign alarm_event = second_update && match &&
		!alarm_disabled;
	// Back-up mode needs its own enable on top of the interrupt enable
	assign irq_permitted = state_reg.alarm_irq_enable &&
		(!backup_mode || state_reg.backup_alarm_enable);
	assign irq_set = alarm_event && irq_permitted;

	// Byte image of the selected register
	always_comb begin
		rbyte = 8'h00;
		unique case (sel)
			SEL_FLAGS: rbyte[AF_BIT] = state_reg.alarm_match_flag;
			SEL_INTERRUPTS: begin
				rbyte[AFE_BIT] = state_reg.alarm_irq_enable;
				rbyte[ABE_BIT] = state_reg.backup_alarm_enable;
			end
			SEL_DATE: begin
				rbyte = state_reg.alarm.date;
				rbyte[RPT_BIT] = state_reg.alarm_repeat_bits[3];
			end
			SEL_HOURS: begin
				rbyte = state_reg.alarm.hours;
				rbyte[RPT_BIT] = state_reg.alarm_repeat_bits[2];
			end
			SEL_MINUTES: begin
				rbyte = state_reg.alarm.minutes;
				rbyte[RPT_BIT] = state_reg.alarm_repeat_bits[1];
			end
			SEL_SECONDS: begin
				rbyte = state_reg.alarm.seconds;
				rbyte[RPT_BIT] = state_reg.alarm_repeat_bits[0];
			end
			SEL_NONE: rbyte = 8'h00;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		state_next.rsp.pready = 1'b0;
		state_next.rsp.pslverr = 1'b0;

		// Answer is prepared in setup, so each access sees fresh data
		if (setup) begin
			state_next.rsp.pready = 1'b1;
			state_next.rsp.pslverr = rsp_error;
			state_next.rsp.prdata = {24'h000000, rbyte};
			state_next.flag_returned = returns_flag;
		end

		// Interrupt enables
		if (wr_interrupts) begin
			state_next.alarm_irq_enable = wbyte[AFE_BIT];
			state_next.backup_alarm_enable = wbyte[ABE_BIT];
		end

		// Each alarm byte carries one of the repeat bits
		if (wr_date) begin
			state_next.alarm.date = date_field;
			state_next.alarm_repeat_bits[3] = wr_repeat_bit;
		end
		if (wr_hours) begin
			state_next.alarm.hours = hours_field;
			state_next.alarm_repeat_bits[2] = wr_repeat_bit;
		end
		if (wr_minutes) begin
			state_next.alarm.minutes = minutes_field;
			state_next.alarm_repeat_bits[1] = wr_repeat_bit;
		end
		if (wr_seconds) begin
			state_next.alarm.seconds = seconds_field;
			state_next.alarm_repeat_bits[0] = wr_repeat_bit;
		end

		// Flag is read-only; a write there changes nothing
		if (wr_flags) begin
			state_next.alarm_match_flag =
				state_reg.alarm_match_flag;
		end

		// Flag and pin are released together by the clearing read
		if (flags_clear) begin
			state_next.alarm_match_flag = 1'b0;
			state_next.irq_low = 1'b0;
		end

		// A match in the clearing cycle wins over the clear
		if (alarm_event) begin
			state_next.alarm_match_flag = 1'b1;
		end
		if (irq_set) begin
			state_next.irq_low = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.alarm <= {4{ALARM_RESET}};
			state_reg.alarm_repeat_bits <= 4'h0;
			state_reg.alarm_irq_enable <= 1'b0;
			state_reg.backup_alarm_enable <= 1'b0;
			state_reg.alarm_match_flag <= 1'b0;
			state_reg.irq_low <= 1'b0;
			state_reg.irq_level <= 1'b0;
			state_reg.flag_returned <= 1'b0;
			state_reg.rsp <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign apb_rsp = state_reg.rsp;
	assign irq_freqtest_out = state_reg.irq_level;
	assign irq_freqtest_oe = state_reg.irq_low;
endmodule

// ---- src/rtc_alarm_pkg.sv ----
package rtc_alarm_pkg;

	// Register indexes; the byte address on the bus is four times the index
	localparam logic [15:0] IDX_FLAGS = 16'h1ff0;
	localparam logic [15:0] IDX_ALARM_SECONDS = 16'h1ff2;
	localparam logic [15:0] IDX_ALARM_MINUTES = 16'h1ff3;
	localparam logic [15:0] IDX_ALARM_HOURS = 16'h1ff4;
	localparam logic [15:0] IDX_ALARM_DATE = 16'h1ff5;
	localparam logic [15:0] IDX_INTERRUPTS = 16'h1ff6;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// Bit positions
	localparam int RPT_BIT = 7;
	localparam int AFE_BIT = 7;
	localparam int ABE_BIT = 5;
	localparam int AF_BIT = 6;

	// Writable field masks of the alarm bytes, repeat bit excluded
	localparam logic [7:0] DATE_MASK = 8'h3f;
	localparam logic [7:0] HOURS_MASK = 8'h3f;
	localparam logic [7:0] MINUTES_MASK = 8'h7f;
	localparam logic [7:0] SECONDS_MASK = 8'h7f;

	// Repeat codes, alarm_repeat_bits 3 down to 0
	localparam logic [3:0] RPT_EVERY_SECOND = 4'hf;
	localparam logic [3:0] RPT_MATCH_SECONDS = 4'he;
	localparam logic [3:0] RPT_MATCH_MINUTES = 4'hc;
	localparam logic [3:0] RPT_MATCH_HOURS = 4'h8;
	localparam logic [3:0] RPT_MATCH_DATE = 4'h0;

	// Field-use masks, bit 0 seconds up to bit 3 date
	localparam logic [3:0] USE_NONE = 4'h0;
	localparam logic [3:0] USE_SECONDS = 4'h1;
	localparam logic [3:0] USE_MINUTES = 4'h3;
	localparam logic [3:0] USE_HOURS = 4'h7;
	localparam logic [3:0] USE_DATE = 4'hf;

	localparam logic [7:0] ALARM_RESET = 8'h00;

	typedef struct packed {
		logic [7:0] date;
		logic [7:0] hours;
		logic [7:0] minutes;
		logic [7:0] seconds;
	} bcd_time_t;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_FLAGS,
		SEL_INTERRUPTS,
		SEL_DATE,
		SEL_HOURS,
		SEL_MINUTES,
		SEL_SECONDS
	} reg_sel_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_t;

endpackage

// ---- verif/rtc_alarm_properties.sv ----
`timescale 1ns/1ns
module rtc_alarm_properties (
	// Design ports
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire rtc_alarm_pkg::apb_req_t apb_req,
	input wire rtc_alarm_pkg::apb_rsp_t apb_rsp,
	input wire rtc_alarm_pkg::bcd_time_t now_time,
	input wire logic second_update,
	input wire logic backup_mode,
	input wire logic irq_freqtest_out,
	input wire logic irq_freqtest_oe
);
	import rtc_alarm_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire setup = apb_req.psel && !apb_req.penable;
	wire fl_rd = apb_req.psel && apb_req.penable && apb_rsp.pready &&
		!apb_req.pwrite && apb_req.paddr == 16'h7fc0;
	rdy_setup_a: assert property (setup |=> apb_rsp.pready)
		else $error("no pready");
	err_data_a: assert property (apb_rsp.pslverr |->
		apb_rsp.pready && apb_rsp.prdata == 32'h0) else $error("bad err");
	upper_zero_a: assert property (apb_rsp.prdata[31:8] == 24'h0)
		else $error("upper bits");
	rdata_hold_a: assert property (apb_rsp.pready |=>
		$stable(apb_rsp.prdata)) else $error("prdata moved");
	pin_low_a: assert property (!irq_freqtest_out)
		else $error("pin level");
	irq_cause_a: assert property ($rose(irq_freqtest_oe) |->
		$past(second_update)) else $error("irq no update");
	irq_clear_a: assert property (fl_rd && apb_rsp.prdata[6] &&
		!second_update |=> !irq_freqtest_oe) else $error("irq kept");
	irq_hold_a: assert property (irq_freqtest_oe && !fl_rd |=>
		irq_freqtest_oe) else $error("irq lost");
endmodule
bind rtc_alarm_match_irq rtc_alarm_properties u_props (.ref_clk(ref_clk),
	.rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.now_time(now_time), .second_update(second_update),
	.backup_mode(backup_mode), .irq_freqtest_out(irq_freqtest_out),
	.irq_freqtest_oe(irq_freqtest_oe));

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
	import rtc_alarm_pkg::*;
	logic ref_clk, rst_n, tick, backup_mode, second_update, oe, po, err;
	apb_req_t apb_req;
	apb_rsp_t apb_rsp;
	bcd_time_t now_time, set_time, t;
	logic [7:0] q;
	logic [7:0] al [4] = '{8'h30, 8'h45, 8'h12, 8'h15};
	logic [3:0] cs [5] = '{4'hf, 4'he, 4'hc, 4'h8, 4'h0};
	logic [3:0] c;
	logic [15:0] r = 16'h49;
	int miscompares = 0, tests_run = 0, flag = 0, irq = 0, i, j;
	rtc_alarm_match_irq u_rtc_alarm_match_irq (.ref_clk(ref_clk),
		.rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.now_time(now_time), .second_update(second_update),
		.backup_mode(backup_mode), .irq_freqtest_out(po),
		.irq_freqtest_oe(oe));
	time_src u_time_src (.ref_clk(ref_clk), .tick(tick),
		.set_time(set_time), .now_time(now_time),
		.second_update(second_update));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		apb_req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!apb_rsp.pready && n < 20);
		q = apb_rsp.prdata[7:0];
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		if (!apb_rsp.pready) begin
			miscompares++;
			close_out();
		end
		@(posedge ref_clk);
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic hit(input logic [3:0] k, input bcd_time_t v);
		logic [3:0] u;
		u = k == 4'he ? 4'h1 : k == 4'hc ? 4'h3 : k == 4'h8 ? 4'h7 :
			k == 4'h0 ? 4'hf : 4'h0;
		return (!u[0] || v.seconds == al[0]) && (!u[1] || v.minutes ==
			al[1]) && (!u[2] || v.hours == al[2]) && (!u[3] || v.date == al[3]);
	endfunction
	initial begin
		apb_req = '0;
		tick = 1'b0;
		set_time = '0;
		backup_mode = 1'b0;
		rst_n = 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		for (i = 0; i < 7; i++) begin
			apb(1'b0, 16'h7fc0 + 16'(4 * i), 8'h0);
			chk("reset", q, 8'h0);
			chk("err", {7'h0, err}, {7'h0, i == 1});
		end
		for (i = 0; i < 30; i++) begin
			r = lfsr(r);
			c = i % 6 == 5 ? r[3:0] : cs[i % 6];
			for (j = 0; j < 4; j++)
				apb(1'b1, 16'h7fc8 + 16'(4 * j), {c[j], al[j][6:0]});
			apb(1'b1, 16'h7fd8, {r[4], 1'b0, r[5], 5'h0});
			backup_mode <= r[6];
			t = {al[3], al[2], al[1], al[0]};
			if (r[7])
				t[8 * r[9:8] +: 8] ^= 8'h01;
			set_time <= t;
			tick <= 1'b1;
			@(posedge ref_clk);
			tick <= 1'b0;
			@(posedge ref_clk);
			if (hit(c, t)) begin
				flag = 1;
				irq = r[4] && (r[5] || !r[6]);
			end
			apb(1'b1, 16'h7fc0, 8'hff);
			chk("oe", {7'h0, oe}, irq[7:0]);
			apb(1'b0, 16'h7fd4, 8'h0);
			chk("date", q, {c[3], al[3][6:0]});
			for (j = 0; j < 2; j++) begin
				apb(1'b0, 16'h7fc0, 8'h0);
				chk("flag", q, 8'(flag << 6));
				flag = 0;
			end
			irq = 0;
			chk("oe", {7'h0, oe}, 8'h0);
			chk("pin", {7'h0, po}, 8'h0);
		end
		for (j = 0; j < 4; j++)
			apb(1'b1, 16'h7fc8 + 16'(4 * j), j == 3 ? 8'h00 : al[j]);
		set_time <= {al[3], al[2], al[1], al[0]};
		tick <= 1'b1;
		@(posedge ref_clk);
		tick <= 1'b0;
		@(posedge ref_clk);
		@(posedge ref_clk);
		apb(1'b0, 16'h7fc0, 8'h0);
		chk("off", q, 8'h0);
		close_out();
	end
endmodule

// ---- verif/time_src.sv ----
`timescale 1ns/1ns
module time_src (
	// Update request
	input wire logic ref_clk,
	input wire logic tick,
	input wire rtc_alarm_pkg::bcd_time_t set_time,
	// Running clock
	output rtc_alarm_pkg::bcd_time_t now_time,
	output logic second_update
);
	import rtc_alarm_pkg::*;
	// Time follows the bench's setting; the pulse marks a new second
	always @(posedge ref_clk) begin
		second_update <= tick;
		now_time <= set_time;
	end
endmodule
